// ==== boot_strap_defines.svh ====
// Named constants for the boot strap decoder: latch layout, reset values, fuse codes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BOOT_STRAP_DEFINES_SVH
`define BOOT_STRAP_DEFINES_SVH

// Latch width and bit positions of the four strapping pins.
`define STRAP_W          4
`define STRAP_A_IDX      0
`define STRAP_B_IDX      1
`define STRAP_C_IDX      2
`define STRAP_D_IDX      3
// Width of the status word that software may read (pins a, b, c).
`define STRAP_STATUS_W   3
// Latch value after power-on reset; pin c rests high through its pull-up.
`define STRAP_RESET_VAL  4'h4
// Level that an undriven pin c takes from the weak pull-up.
`define STRAP_C_PULL     1'h1

// Print policy fuse codes.
`define PRINT_ALWAYS     2'h0
`define PRINT_WHEN_B_LOW 2'h1
`define PRINT_WHEN_B_HI  2'h2
`define PRINT_NEVER      2'h3

// Print channel fuse codes.
`define CHAN_USB         1'h0
`define CHAN_SERIAL      1'h1

`endif

// ==== boot_strap_pkg.sv ====
// Types shared by the boot strap decoder and its strap sampler.
// Assumes boot_strap_defines.svh sits in the same folder.
`include "boot_strap_defines.svh"

package boot_strap_pkg;

    // Boot mode chosen from straps, fuses and override requests.
    typedef enum logic [1:0] {
        BOOT_SPI,
        BOOT_DOWNLOAD,
        BOOT_INVALID
    } boot_mode_e;

    // Source of the debug port signals.
    typedef enum logic [1:0] {
        DBG_PINS,
        DBG_USB,
        DBG_OFF
    } debug_src_e;

    // Pending override from the USB serial/debug controller.
    typedef enum logic [1:0] {
        OVR_NONE,
        OVR_TO_DOWNLOAD,
        OVR_TO_SPI
    } usb_ovr_e;

    typedef logic [`STRAP_W-1:0] strap_t;

endpackage : boot_strap_pkg

// ==== strap_if.sv ====
// Carrier between the decoder and its strap sampler.
// Assumes the decoder drives capture and pin levels and the sampler returns the latch.
`timescale 1ns/1ns

interface strap_if;
    logic                    capture;
    boot_strap_pkg::strap_t  pin_level;
    boot_strap_pkg::strap_t  latched;

    modport sampler (input capture, input pin_level, output latched);
    modport owner   (output capture, output pin_level, input latched);
endinterface : strap_if

// ==== strap_sampler.sv ====
// Latch bank that holds the strapping pin levels taken during a system reset.
// Assumes capture is high only while a power-on class system reset is in progress.
`timescale 1ns/1ns
`include "boot_strap_defines.svh"

module strap_sampler (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Capture control, pin levels and latch contents.
    strap_if.sampler  sif
);
    import boot_strap_pkg::*;

    // Latches follow the pins while capture is high and freeze when it falls.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sif.latched <= `STRAP_RESET_VAL;
        end else if (sif.capture) begin
            sif.latched <= sif.pin_level;
        end
    end

    // Once capture is low the latch must not move.
    latch_hold_a: assert property (@(posedge clk) disable iff (rst)
        !sif.capture |=> $stable(sif.latched))
        else $error("strap latch changed outside capture");

endmodule : strap_sampler

// ==== boot_strap_decoder.sv ====
// Boot strap decoder: latches strapping pins and decodes boot, print and debug choices.
// Assumes synchronous pin inputs, static fuse inputs and one-cycle cpu_reset and USB pulses.
`timescale 1ns/1ns
`include "boot_strap_defines.svh"

module boot_strap_decoder (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Reset sequence controls.
    input  wire logic                     strap_capture,
    input  wire logic                     cpu_reset,
    // Strapping pins.
    input  wire logic                     strap_pin_a,
    input  wire logic                     strap_pin_b,
    input  wire logic                     strap_pin_c,
    input  wire logic                     strap_pin_c_driven,
    input  wire logic                     strap_pin_d,
    // Software and USB controller requests.
    input  wire logic                     force_download_request,
    input  wire logic                     usb_req_download,
    input  wire logic                     usb_req_spi,
    input  wire logic                     usb_controller_enabled,
    // Fuses.
    input  wire logic                     fuse_block_force_download,
    input  wire logic                     fuse_download_disable,
    input  wire logic                     fuse_secure_download,
    input  wire logic [1:0]               fuse_print_policy,
    input  wire logic                     fuse_print_channel,
    input  wire logic                     fuse_pin_debug_disable,
    input  wire logic                     fuse_usb_debug_disable,
    input  wire logic                     fuse_debug_strap_select,
    // Status and decoded outputs.
    output logic [`STRAP_STATUS_W-1:0]    strap_status,
    output logic                          pins_functional,
    output boot_strap_pkg::boot_mode_e    boot_mode,
    output logic                          boot_invalid,
    output logic                          download_restricted,
    output logic                          print_to_usb,
    output logic                          print_to_serial,
    output boot_strap_pkg::debug_src_e    debug_source
);
    import boot_strap_pkg::*;

    strap_if    sif ();
    logic       capture_q;
    logic       boot_eval;
    logic       force_now;
    logic       sa;
    logic       sb;
    logic       sc;
    logic       sd;
    logic       print_en;
    usb_ovr_e   usb_ovr_q;
    boot_mode_e strap_mode;
    boot_mode_e mode_d;
    debug_src_e dbg_d;

    // Pin c falls back to the pull-up level when nobody drives it.
    assign sif.capture   = strap_capture;
    assign sif.pin_level = {strap_pin_d,
                            strap_pin_c_driven ? strap_pin_c : `STRAP_C_PULL,
                            strap_pin_b, strap_pin_a};

    strap_sampler i_strap_sampler (
        .clk (clk),
        .rst (rst),
        .sif (sif.sampler)
    );

    assign sa = sif.latched[`STRAP_A_IDX];
    assign sb = sif.latched[`STRAP_B_IDX];
    assign sc = sif.latched[`STRAP_C_IDX];
    assign sd = sif.latched[`STRAP_D_IDX];

    // Software sees straps a to c straight from the latch flops.
    assign strap_status = sif.latched[`STRAP_STATUS_W-1:0];

    // Track capture so its end can trigger the first boot decision.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_q       <= 1'b0;
            pins_functional <= 1'b0;
        end else begin
            capture_q       <= strap_capture;
            pins_functional <= !strap_capture;
        end
    end

    // Decisions happen when the strap latch closes and at every CPU reset.
    assign boot_eval = (capture_q && !strap_capture) || cpu_reset;
    assign force_now = cpu_reset && force_download_request && !fuse_block_force_download;

    // USB overrides stay pending until consumed; a new request wins over consumption.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            usb_ovr_q <= OVR_NONE;
        end else if (usb_req_download) begin
            usb_ovr_q <= OVR_TO_DOWNLOAD;
        end else if (usb_req_spi) begin
            usb_ovr_q <= OVR_TO_SPI;
        end else if (boot_eval) begin
            usb_ovr_q <= OVR_NONE;
        end
    end

    // Boot mode from straps, then overrides, then the download-disable fuse.
    always_comb begin
        if (sa && sc) begin
            strap_mode = BOOT_SPI;
        end else if (sa && sb && !sc) begin
            strap_mode = BOOT_DOWNLOAD;
        end else begin
            strap_mode = BOOT_INVALID;
        end
        mode_d = strap_mode;
        if (strap_mode == BOOT_SPI && (force_now || usb_ovr_q == OVR_TO_DOWNLOAD)) begin
            mode_d = BOOT_DOWNLOAD;
        end else if (strap_mode == BOOT_DOWNLOAD && usb_ovr_q == OVR_TO_SPI) begin
            mode_d = BOOT_SPI;
        end
        if (mode_d == BOOT_DOWNLOAD && fuse_download_disable) begin
            mode_d = BOOT_INVALID;
        end
    end

    // Boot mode register, refreshed on each decision point.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_mode    <= BOOT_INVALID;
            boot_invalid <= 1'b0;
        end else if (boot_eval) begin
            boot_mode    <= mode_d;
            boot_invalid <= (mode_d == BOOT_INVALID);
        end
    end

    // Secure download only applies while download boot is actually active.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            download_restricted <= 1'b0;
        end else begin
            download_restricted <= fuse_secure_download && !fuse_download_disable
                                   && boot_mode == BOOT_DOWNLOAD;
        end
    end

    // Print enable from policy fuse and strap b.
    always_comb begin
        unique case (fuse_print_policy)
            `PRINT_ALWAYS:     print_en = 1'b1;
            `PRINT_WHEN_B_LOW: print_en = !sb;
            `PRINT_WHEN_B_HI:  print_en = sb;
            `PRINT_NEVER:      print_en = 1'b0;
        endcase
    end

    // Print routing; a disabled USB controller silences USB printing.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            print_to_usb    <= 1'b0;
            print_to_serial <= 1'b0;
        end else begin
            print_to_usb    <= print_en && fuse_print_channel == `CHAN_USB
                               && usb_controller_enabled;
            print_to_serial <= print_en && fuse_print_channel == `CHAN_SERIAL;
        end
    end

    // Debug source from the two disable fuses, the select fuse and strap d.
    always_comb begin
        unique case ({fuse_pin_debug_disable, fuse_usb_debug_disable})
            2'b00:   dbg_d = !fuse_debug_strap_select ? DBG_USB
                             : (sd ? DBG_USB : DBG_PINS);
            2'b01:   dbg_d = DBG_PINS;
            2'b10:   dbg_d = DBG_USB;
            default: dbg_d = DBG_OFF;
        endcase
    end

    // Debug source register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debug_source <= DBG_OFF;
        end else begin
            debug_source <= dbg_d;
        end
    end

    // Checks on the decoded outputs.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence spi_straps_s;
        boot_eval && sa && sc && !force_now && usb_ovr_q == OVR_NONE;
    endsequence

    sequence force_spi_s;
        cpu_reset && force_download_request && !fuse_block_force_download
        && sa && sc && !fuse_download_disable;
    endsequence

    status_map_a: assert property (sif.capture |=> strap_status == {
        $past(sif.pin_level[`STRAP_C_IDX]),
        $past(sif.pin_level[`STRAP_B_IDX]),
        $past(sif.pin_level[`STRAP_A_IDX])})
        else $error("strap status does not show latch");
    pins_release_a: assert property ($fell(strap_capture) |=> pins_functional)
        else $error("pins not released after capture");
    spi_decode_a: assert property (spi_straps_s |=> boot_mode == BOOT_SPI)
        else $error("spi straps did not give spi boot");
    force_dl_a: assert property (force_spi_s |=> boot_mode == BOOT_DOWNLOAD)
        else $error("force download request ignored");
    block_force_a: assert property (cpu_reset && fuse_block_force_download && sa && sc
        && usb_ovr_q == OVR_NONE |=> boot_mode == BOOT_SPI)
        else $error("blocked force download took effect");
    no_download_a: assert property (boot_eval && fuse_download_disable
        |=> boot_mode != BOOT_DOWNLOAD)
        else $error("download entered while disabled");
    secure_dl_a: assert property (download_restricted |-> $past(boot_mode) == BOOT_DOWNLOAD)
        else $error("restriction outside download boot");
    print_never_a: assert property (fuse_print_policy == `PRINT_NEVER
        |=> !print_to_usb && !print_to_serial)
        else $error("printing under never policy");
    usb_off_a: assert property (!usb_controller_enabled |=> !print_to_usb)
        else $error("usb print with controller disabled");
    debug_off_a: assert property (fuse_pin_debug_disable && fuse_usb_debug_disable
        |=> debug_source == DBG_OFF)
        else $error("debug not disabled");
    invalid_flag_a: assert property (boot_eval && !sa |=> boot_invalid)
        else $error("invalid straps not flagged");

endmodule : boot_strap_decoder

// ==== strap_pin_model.sv ====
// Board side of the strapping pins: pull resistors or a host driving levels.
// Assumes the bench sets the levels before it opens the capture window.
`timescale 1ns/1ns

module strap_pin_model (
    // Clock.
    input  wire logic       clk,
    // Requested levels {d,c,b,a} and whether pin c is driven.
    input  wire logic [3:0] level,
    input  wire logic       c_drive,
    // Levels seen by the device.
    output logic [3:0]      pin,
    output logic            c_driven
);
    // Direct flash boot needs this pattern at the head of the flash image; the board keeps it.
    localparam logic [31:0] flash_boot_pattern = 32'haebd_041d;

    logic junk_q = 1'h0;

    // An undriven pin c shows a changing value, so only the pull-up can make it high.
    always_ff @(posedge clk) begin
        junk_q <= ~junk_q;
    end

    // Drive the pins from the requested levels.
    assign pin      = {level[3], c_drive ? level[2] : junk_q, level[1:0]};
    assign c_driven = c_drive;
endmodule : strap_pin_model

// ==== tb_boot_strap_decoder.sv ====
// Self-checking bench for the boot strap decoder.
// Assumes the decoder files and the strap pin model are compiled first.
`timescale 1ns/1ns

module tb_boot_strap_decoder;
    import boot_strap_pkg::*;

    logic clk = 0, rst = 1, cap = 0, cpu_rst = 0, force_req = 0;
    logic usb_dl = 0, usb_spi = 0, usb_en = 1, f_blk = 0, f_dis = 0, f_sec = 0;
    logic f_chan = 1, f_pin = 0, f_usb = 0, f_sel = 0, c_drv = 0, c_dvn, en;
    logic [1:0] f_pol = 2'h0;
    logic [3:0] lvl = 4'h0, pin;
    logic [2:0] status;
    logic       pins_fn, binv, dres, p_usb, p_ser;
    boot_mode_e mode;
    debug_src_e dbg, de;
    int         failures = 0;
    int         check_count = 0;

    // Clock at 125 MHz.
    always #4 clk = ~clk;

    strap_pin_model i_strap_pin_model (.clk(clk), .level(lvl), .c_drive(c_drv),
        .pin(pin), .c_driven(c_dvn));

    boot_strap_decoder i_boot_strap_decoder (.clk(clk), .rst(rst), .strap_capture(cap),
        .cpu_reset(cpu_rst), .strap_pin_a(pin[0]), .strap_pin_b(pin[1]),
        .strap_pin_c(pin[2]), .strap_pin_c_driven(c_dvn), .strap_pin_d(pin[3]),
        .force_download_request(force_req), .usb_req_download(usb_dl),
        .usb_req_spi(usb_spi), .usb_controller_enabled(usb_en),
        .fuse_block_force_download(f_blk), .fuse_download_disable(f_dis),
        .fuse_secure_download(f_sec), .fuse_print_policy(f_pol),
        .fuse_print_channel(f_chan), .fuse_pin_debug_disable(f_pin),
        .fuse_usb_debug_disable(f_usb), .fuse_debug_strap_select(f_sel),
        .strap_status(status), .pins_functional(pins_fn), .boot_mode(mode),
        .boot_invalid(binv), .download_restricted(dres), .print_to_usb(p_usb),
        .print_to_serial(p_ser), .debug_source(dbg));

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // One capture window with the given levels, then wait for the decision.
    task automatic strap(input logic [3:0] l, input logic cd);
        lvl = l;
        c_drv = cd;
        cap = 1;
        tick(1);
        chk("pins_fn", 3'h0, {2'h0, pins_fn});
        cap = 0;
        tick(3);
    endtask : strap

    // One CPU reset pulse, then wait for the new decision.
    task automatic boot();
        cpu_rst = 1;
        tick(1);
        cpu_rst = 0;
        tick(2);
    endtask : boot

    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // A hang ends the run as a failure.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end

    // Main sequence.
    initial begin
        tick(20);
        rst = 0;
        tick(1);
        chk("status", 3'h4, status);
        strap(4'h1, 1'h0);
        chk("status", 3'h5, status);
        chk("mode", {1'b0, BOOT_SPI}, {1'b0, mode});
        chk("invalid", 3'h0, {2'h0, binv});
        chk("pins_fn", 3'h1, {2'h0, pins_fn});
        lvl = 4'h2;
        c_drv = 1;
        tick(3);
        chk("status", 3'h5, status);
        chk("mode", {1'b0, BOOT_SPI}, {1'b0, mode});
        strap(4'h7, 1'h1);
        chk("mode", {1'b0, BOOT_SPI}, {1'b0, mode});
        f_sec = 1;
        strap(4'h3, 1'h1);
        chk("mode", {1'b0, BOOT_DOWNLOAD}, {1'b0, mode});
        chk("restricted", 3'h1, {2'h0, dres});
        f_dis = 1;
        strap(4'h3, 1'h1);
        chk("mode", {1'b0, BOOT_INVALID}, {1'b0, mode});
        chk("restricted", 3'h0, {2'h0, dres});
        f_dis = 0;
        f_sec = 0;
        strap(4'h6, 1'h1);
        chk("invalid", 3'h1, {2'h0, binv});
        // Pin c driven low is taken as low; a=1, b=0, c=0 matches no boot mode.
        strap(4'h1, 1'h1);
        chk("status", 3'h1, status);
        chk("mode", {1'b0, BOOT_INVALID}, {1'b0, mode});
        chk("invalid", 3'h1, {2'h0, binv});
        strap(4'h5, 1'h1);
        force_req = 1;
        boot();
        chk("mode", {1'b0, BOOT_DOWNLOAD}, {1'b0, mode});
        f_blk = 1;
        boot();
        chk("mode", {1'b0, BOOT_SPI}, {1'b0, mode});
        force_req = 0;
        f_blk = 0;
        usb_dl = 1;
        tick(1);
        usb_dl = 0;
        tick(1);
        boot();
        chk("mode", {1'b0, BOOT_DOWNLOAD}, {1'b0, mode});
        strap(4'h3, 1'h1);
        usb_spi = 1;
        tick(1);
        usb_spi = 0;
        tick(1);
        boot();
        chk("mode", {1'b0, BOOT_SPI}, {1'b0, mode});
        // Every print policy, channel and controller state for both levels of b.
        for (int b = 0; b < 2; b++) begin
            strap({2'b01, b[0], 1'b1}, 1'h1);
            for (int k = 0; k < 16; k++) begin
                {f_pol, f_chan, usb_en} = k[3:0];
                tick(2);
                en = (f_pol == 2'h0) | (f_pol == 2'h1 & !b[0]) | (f_pol == 2'h2 & b[0]);
                chk("serial", {2'h0, en & f_chan}, {2'h0, p_ser});
                chk("usb", {2'h0, en & !f_chan & usb_en}, {2'h0, p_usb});
            end
        end
        // Every debug fuse combination for both levels of d.
        for (int d = 0; d < 2; d++) begin
            strap({d[0], 3'h5}, 1'h1);
            for (int k = 0; k < 8; k++) begin
                {f_pin, f_usb, f_sel} = k[2:0];
                tick(2);
                if (f_pin & f_usb) begin
                    de = DBG_OFF;
                end else if (f_pin) begin
                    de = DBG_USB;
                end else if (f_usb || (f_sel && !d[0])) begin
                    de = DBG_PINS;
                end else begin
                    de = DBG_USB;
                end
                chk("debug", {1'b0, de}, {1'b0, dbg});
            end
        end
        complete_run();
    end
endmodule : tb_boot_strap_decoder
